// ===== design/program_space_address_mapper_consts.svh
// constants for the program space address mapper
`ifndef PROGRAM_SPACE_ADDRESS_MAPPER_CONSTS_SVH
`define PROGRAM_SPACE_ADDRESS_MAPPER_CONSTS_SVH
// register indices on the plain register port
`define REG_TABLE_PAGE 2'h0
`define REG_VISIBILITY_PAGE 2'h1
`define REG_CORE_CONTROL 2'h2
`define REG_STATUS 2'h3
// field positions
`define CORE_CONTROL_VISIBILITY_BIT 2
`define TABLE_PAGE_CONFIG_BIT 7
`define EA_MAP_BIT 15
// reset values
`define TABLE_PAGE_RESET 8'h00
`define VISIBILITY_PAGE_RESET 8'h00
`define CORE_CONTROL_RESET 16'h0000
`define PC_RESET 23'h000000
// user program range
`define USER_PROGRAM_LAST 24'h7ffffe
// data space layout
`define Y_BLOCK_FIRST 16'h0800
`define Y_BLOCK_LAST 16'h0bff
`define DATA_IMPL_LAST 16'h0fff
// mapped access penalties in cycles
`define PENALTY_SHORT 2'h1
`define PENALTY_LONG 2'h2
`define PENALTY_NONE 2'h0
`endif

// ===== design/program_space_address_mapper_pkg.sv
// types for the program space address mapper
package program_space_address_mapper_pkg;
  typedef enum logic [2:0] {
    ACCESS_DATA,
    TABLE_READ_LOW,
    TABLE_READ_HIGH,
    TABLE_WRITE_LOW,
    TABLE_WRITE_HIGH
  } access_kind_t;
  typedef enum logic [1:0] {
    CLASS_DUAL_PREFETCH,
    CLASS_MOVE,
    CLASS_DOUBLE_MOVE,
    CLASS_OTHER
  } instr_class_t;
  typedef enum logic [2:0] {
    X_POINTER_A,
    X_POINTER_B,
    Y_POINTER_A,
    Y_POINTER_B,
    POINTER_OTHER
  } pointer_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_CAPTURE,
    ST_PENALTY
  } mapper_state_t;
endpackage

// ===== design/program_space_address_mapper.sv
// program address construction, table steering and mapped data access
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "program_space_address_mapper_consts.svh"

// Behaviour
// (R1) fetch address is 0, pc bits, 0
// (R2) fetch address steps by two per word
// (R3) non-table accesses stay within user range
// (R4) table page top bit picks config space
// (R5) table address is page byte plus ea
// (R6) bit 23 set only by table accesses
// (R7) mapped address is 0, page, ea 14:0
// (R8) low word read returns program bits 15:0
// (R9) low byte read picks by byte select
// (R10) high word read zero-extends bits 23:16
// (R11) high byte read: top byte or zero
// (R12) top byte reachable only via high table ops
// (R13) map only when ea msb and enable set
// (R14) upper data half maps to one page
// (R15) mapped read returns low 16 bits only
// (R16) mapping suspended during table accesses
// (R17) outside repeat: one or two extra cycles
// (R18) inside repeat: two at edges, else none
// (R19) y block sits inside linear x space
// (R20) plain instructions see whole data space
// (R21) dual operand: y and x pointer regions
// (R22) x and y concurrent only for dual operand
// (R23) invalid address returns all zeros
// (R24) address combinational, penalty stalls pipeline
module program_space_address_mapper
  import program_space_address_mapper_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // program counter control
  input wire logic pc_load,
  input wire logic [22:0] pc_load_value,
  input wire logic pc_advance,
  output logic [23:0] fetch_address,
  // access request from the execution unit
  input wire logic req,
  input wire program_space_address_mapper_pkg::access_kind_t req_kind,
  input wire program_space_address_mapper_pkg::instr_class_t req_class,
  input wire logic req_byte,
  input wire logic req_dual,
  input wire logic [15:0] req_x_ea,
  input wire program_space_address_mapper_pkg::pointer_t req_x_pointer,
  input wire logic [15:0] req_y_ea,
  input wire program_space_address_mapper_pkg::pointer_t req_y_pointer,
  input wire logic [15:0] req_wdata,
  input wire logic repeat_active,
  input wire logic repeat_boundary,
  output logic stall,
  output logic result_valid,
  output logic [15:0] x_result,
  output logic [15:0] y_result,
  // program memory
  output logic prog_read,
  output logic prog_write,
  output logic [2:0] prog_byte_enable,
  output logic [23:0] prog_addr,
  output logic [23:0] prog_wdata,
  input wire logic [23:0] prog_rdata,
  // x and y data memory paths
  output logic x_read,
  output logic [15:0] x_addr,
  input wire logic [15:0] x_rdata,
  output logic y_read,
  output logic [15:0] y_addr,
  input wire logic [15:0] y_rdata
);
  import program_space_address_mapper_pkg::*;

  // reset release synchroniser
  logic reset_meta_n;
  logic rst_n;

  // software visible control
  logic [7:0] table_page_select;
  logic [7:0] visibility_page_select;
  logic [15:0] core_control;
  logic program_visibility_enable;

  // program counter, word aligned
  logic [22:0] pc;

  // request hold registers
  access_kind_t kind_q;
  logic byte_q;
  logic sel_q;
  logic mapped_q;
  logic x_ok_q;
  logic y_ok_q;
  logic dual_q;
  logic [1:0] penalty_q;

  // sequencer
  mapper_state_t state;
  mapper_state_t next_state;
  logic [1:0] count;

  // combinational address generator
  logic is_table;
  logic mapped;
  logic [23:0] table_address;
  logic [23:0] mapped_address;
  logic [23:0] next_prog_addr;
  logic [1:0] next_penalty;
  logic x_ok;
  logic y_ok;
  logic x_in_y;
  logic y_in_y;

  // release reset through two flops
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      reset_meta_n <= 1'b1;
      rst_n <= reset_meta_n;
    end
  end

  // register writes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      table_page_select <= `TABLE_PAGE_RESET;
      visibility_page_select <= `VISIBILITY_PAGE_RESET;
      core_control <= `CORE_CONTROL_RESET;
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        `REG_TABLE_PAGE: table_page_select <= reg_wdata[7:0];
        `REG_VISIBILITY_PAGE: visibility_page_select <= reg_wdata[7:0];
        `REG_CORE_CONTROL: core_control <= reg_wdata;
        // status is read only
        `REG_STATUS: ;
      endcase
    end
  end

  assign program_visibility_enable = core_control[`CORE_CONTROL_VISIBILITY_BIT];

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      unique case (reg_addr)
        `REG_TABLE_PAGE: reg_rdata <= {8'h00, table_page_select};
        `REG_VISIBILITY_PAGE: reg_rdata <= {8'h00, visibility_page_select};
        `REG_CORE_CONTROL: reg_rdata <= core_control;
        `REG_STATUS: reg_rdata <= {11'h000, mapped_q, penalty_q, state};
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // program counter: load wins over advance
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pc <= `PC_RESET;
    else if (pc_load)
      pc <= {pc_load_value[22:1], 1'b0};
    else if (pc_advance)
      pc <= pc + 23'h000002; // [R2]
  end

  // fetch address: top bit clear, pc, low bit clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fetch_address <= 24'h000000;
    else
      fetch_address <= {1'b0, pc[22:1], 1'b0}; // [R1] [R6]
  end

  // address generation, purely combinational so no cycle is spent here
  always_comb
  begin
    is_table = (req_kind != ACCESS_DATA);
    // mapping is off while a table access runs
    mapped = !is_table && req_x_ea[`EA_MAP_BIT] && program_visibility_enable; // [R13] [R16]
    // page byte above the ea; page top bit chooses config space
    table_address = {table_page_select, req_x_ea}; // [R4] [R5] [R6]
    // one 16k word page behind the upper 32 kbytes
    mapped_address = {1'b0, visibility_page_select, req_x_ea[14:0]}; // [R7] [R14] [R24]
    if (is_table)
      next_prog_addr = table_address;
    else
      // only bit 23 is cleared to stay in user space; bit 0 keeps the ea byte lane
      next_prog_addr = {1'b0, mapped_address[22:0]}; // [R3] [R6]
  end

  // region checks for the two data paths
  always_comb
  begin
    x_in_y = (req_x_ea >= `Y_BLOCK_FIRST) && (req_x_ea <= `Y_BLOCK_LAST);
    y_in_y = (req_y_ea >= `Y_BLOCK_FIRST) && (req_y_ea <= `Y_BLOCK_LAST);
    if (req_dual)
    begin
      // x pointers must avoid the y block, y pointers must stay in it
      x_ok = (req_x_pointer == X_POINTER_A || req_x_pointer == X_POINTER_B)
        && !x_in_y && (mapped || req_x_ea <= `DATA_IMPL_LAST); // [R21] [R23]
      y_ok = (req_y_pointer == Y_POINTER_A || req_y_pointer == Y_POINTER_B)
        && y_in_y; // [R21] [R23]
    end
    else
    begin
      // one linear space, y block included
      x_ok = mapped || req_x_ea <= `DATA_IMPL_LAST; // [R19] [R20] [R23]
      y_ok = 1'b0; // [R22]
    end
  end

  // added cycles for a mapped access
  always_comb
  begin
    if (!mapped)
      next_penalty = `PENALTY_NONE;
    else if (repeat_active)
      next_penalty = repeat_boundary ? `PENALTY_LONG : `PENALTY_NONE; // [R18]
    else if (req_class == CLASS_OTHER)
      next_penalty = `PENALTY_LONG; // [R17]
    else
      next_penalty = `PENALTY_SHORT; // [R17]
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (req) next_state = ST_ACCESS;
      ST_ACCESS: next_state = ST_CAPTURE;
      ST_CAPTURE: if (penalty_q != `PENALTY_NONE) next_state = ST_PENALTY;
        else next_state = ST_IDLE;
      ST_PENALTY: if (count == 2'h1) next_state = ST_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // penalty cycle counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count <= 2'h0;
    else if (state == ST_CAPTURE)
      count <= penalty_q;
    else if (state == ST_PENALTY)
      count <= count - 2'h1;
  end

  // pipeline held while a request is in flight
  assign stall = (state != ST_IDLE); // [R24]

  // capture the request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kind_q <= ACCESS_DATA;
      byte_q <= 1'b0;
      sel_q <= 1'b0;
      mapped_q <= 1'b0;
      x_ok_q <= 1'b0;
      y_ok_q <= 1'b0;
      dual_q <= 1'b0;
      penalty_q <= `PENALTY_NONE;
    end
    else if (state == ST_IDLE && req)
    begin
      kind_q <= req_kind;
      byte_q <= req_byte;
      sel_q <= req_x_ea[0];
      mapped_q <= mapped;
      x_ok_q <= x_ok;
      y_ok_q <= y_ok;
      dual_q <= req_dual;
      penalty_q <= next_penalty;
    end
  end

  // memory strobes and addresses
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_read <= 1'b0;
      prog_write <= 1'b0;
      prog_byte_enable <= 3'h0;
      prog_addr <= 24'h000000;
      prog_wdata <= 24'h000000;
      x_read <= 1'b0;
      x_addr <= 16'h0000;
      y_read <= 1'b0;
      y_addr <= 16'h0000;
    end
    else if (state == ST_IDLE && req)
    begin
      prog_addr <= next_prog_addr;
      x_addr <= req_x_ea;
      y_addr <= req_y_ea;
      // reads go out only to valid places
      prog_read <= (req_kind == TABLE_READ_LOW) || (req_kind == TABLE_READ_HIGH)
        || (mapped && x_ok);
      x_read <= (req_kind == ACCESS_DATA) && !mapped && x_ok;
      y_read <= y_ok; // [R22]
      // low writes reach the low word, high writes only the top byte
      prog_write <= (req_kind == TABLE_WRITE_LOW) || (req_kind == TABLE_WRITE_HIGH);
      if (req_kind == TABLE_WRITE_HIGH)
      begin
        prog_byte_enable <= 3'h4; // [R12]
        prog_wdata <= {req_wdata[7:0], 16'h0000};
      end
      else if (req_kind == TABLE_WRITE_LOW)
      begin
        if (req_byte)
          prog_byte_enable <= req_x_ea[0] ? 3'h2 : 3'h1;
        else
          prog_byte_enable <= 3'h3;
        prog_wdata <= {8'h00, req_byte ? {2{req_wdata[7:0]}} : req_wdata};
      end
      else
      begin
        prog_byte_enable <= 3'h0;
        prog_wdata <= 24'h000000;
      end
    end
    else
    begin
      prog_read <= 1'b0;
      prog_write <= 1'b0;
      prog_byte_enable <= 3'h0;
      x_read <= 1'b0;
      y_read <= 1'b0;
    end
  end

  // byte or word of the low program word
  function automatic logic [15:0] low_steer(input logic [15:0] w, input logic b,
    input logic s);
    if (!b)
      low_steer = w; // [R8]
    else if (s)
      low_steer = {8'h00, w[15:8]}; // [R9]
    else
      low_steer = {8'h00, w[7:0]}; // [R9]
  endfunction

  // top byte of the program word, zero filled
  function automatic logic [15:0] high_steer(input logic [7:0] t, input logic b,
    input logic s);
    if (b && s)
      high_steer = 16'h0000; // [R11]
    else
      high_steer = {8'h00, t}; // [R10] [R11]
  endfunction

  // steer returned data into the result registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      x_result <= 16'h0000;
      y_result <= 16'h0000;
    end
    else if (state == ST_CAPTURE)
    begin
      unique case (kind_q)
        TABLE_READ_LOW: x_result <= low_steer(prog_rdata[15:0], byte_q, sel_q);
        TABLE_READ_HIGH: x_result <= high_steer(prog_rdata[23:16], byte_q, sel_q); // [R12]
        ACCESS_DATA:
        begin
          if (!x_ok_q)
            x_result <= 16'h0000; // [R23]
          else if (mapped_q)
            x_result <= low_steer(prog_rdata[15:0], byte_q, sel_q); // [R15]
          else
            x_result <= low_steer(x_rdata, byte_q, sel_q);
        end
        TABLE_WRITE_LOW, TABLE_WRITE_HIGH: x_result <= 16'h0000;
      endcase
      // y path words only, zero when misused
      y_result <= (dual_q && y_ok_q) ? y_rdata : 16'h0000; // [R22] [R23]
    end
  end

  // completion pulse after any added cycles
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      result_valid <= 1'b0;
    else
      result_valid <= (state != ST_IDLE) && (next_state == ST_IDLE);
  end
endmodule

// ===== verification/program_space_address_mapper_props.sv
// port-level checks for the program space address mapper
`timescale 1ns/1ps
module program_space_address_mapper_props
  import program_space_address_mapper_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic pc_load,
  input wire logic pc_advance,
  input wire logic [23:0] fetch_address,
  input wire logic req,
  input wire program_space_address_mapper_pkg::access_kind_t req_kind,
  input wire logic req_dual,
  input wire logic [15:0] req_x_ea,
  input wire logic stall,
  input wire logic result_valid,
  input wire logic [15:0] x_result,
  input wire logic prog_read,
  input wire logic prog_write,
  input wire logic [2:0] prog_byte_enable,
  input wire logic [23:0] prog_addr,
  input wire logic y_read
);
  logic [7:0] page; // table page shadow
  logic [7:0] vpage; // visibility page shadow
  logic map_en; // visibility enable shadow
  logic take; // request accepted at this edge
  assign take = req && !stall;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // shadows let the address checks work from the ports alone
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      page <= 8'h00;
      vpage <= 8'h00;
      map_en <= 1'b0;
    end
    else if (reg_write)
    begin
      if (reg_addr == 2'h0) page <= reg_wdata[7:0];
      if (reg_addr == 2'h1) vpage <= reg_wdata[7:0];
      if (reg_addr == 2'h2) map_en <= reg_wdata[2];
    end
  end
  a_fetch_shape: assert property (!fetch_address[23] && !fetch_address[0])
    else $error("fetch address has a stray bit");
  a_fetch_step: assert property (pc_advance && !pc_load |=> ##1
    fetch_address == (($past(fetch_address) + 24'h2) & 24'h7ffffe))
    else $error("fetch address did not step by two");
  a_stall_take: assert property (take |=> stall)
    else $error("accepted request did not stall");
  a_table_time: assert property (take && req_kind != ACCESS_DATA |-> ##3 result_valid)
    else $error("table access took extra cycles");
  a_table_addr: assert property (take && req_kind != ACCESS_DATA |=>
    prog_addr == {page, $past(req_x_ea)})
    else $error("table address not page and ea");
  a_map_gate: assert property (take && req_kind == ACCESS_DATA |=>
    prog_read == ($past(req_x_ea[15]) && map_en) && !prog_write)
    else $error("data access reached program memory wrongly");
  a_map_addr: assert property (take && req_kind == ACCESS_DATA && req_x_ea[15] && map_en |=>
    prog_addr == {1'b0, vpage, $past(req_x_ea[14:0])})
    else $error("mapped address malformed");
  a_write_lane: assert property (take && req_kind == TABLE_WRITE_HIGH |=>
    prog_write && prog_byte_enable == 3'h4)
    else $error("high table write touched the low word");
  a_high_zero: assert property (take && req_kind == TABLE_READ_HIGH |-> ##3
    x_result[15:8] == 8'h00)
    else $error("high table read upper byte not zero");
  a_y_dual: assert property (take && !req_dual |=> !y_read)
    else $error("y path used outside dual operand");
endmodule

// ===== verification/program_memory_model.sv
// behavioural program and data memories answering one cycle after a read
`timescale 1ns/1ps
module program_memory_model
(
  input wire logic clock,
  input wire logic prog_read,
  input wire logic [23:0] prog_addr,
  input wire logic x_read,
  input wire logic [15:0] x_addr,
  input wire logic y_read,
  input wire logic [15:0] y_addr,
  output logic [23:0] prog_rdata,
  output logic [15:0] x_rdata,
  output logic [15:0] y_rdata
);
  initial
  begin
    prog_rdata = 24'h000000;
    x_rdata = 16'h0000;
    y_rdata = 16'h0000;
  end
  // valid only right after a read; otherwise flip so stale sampling shows
  always @(posedge clock)
  begin
    prog_rdata <= prog_read ? {prog_addr[7:0] ^ 8'h3c, prog_addr[15:0] ^ prog_addr[23:8]}
      : ~prog_rdata;
    x_rdata <= x_read ? x_addr ^ 16'h6d2b : ~x_rdata;
    y_rdata <= y_read ? y_addr ^ 16'h1e97 : ~y_rdata;
  end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the program space address mapper
`timescale 1ns/1ps
module testbench;
  import program_space_address_mapper_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0, reg_read = 1'b0, pc_load = 1'b0, pc_advance = 1'b0;
  logic [22:0] pc_load_value = 23'h000000;
  logic req = 1'b0, req_byte = 1'b0, req_dual = 1'b0;
  logic repeat_active = 1'b0, repeat_boundary = 1'b0;
  access_kind_t req_kind = ACCESS_DATA;
  instr_class_t req_class = CLASS_OTHER;
  pointer_t req_x_pointer = POINTER_OTHER, req_y_pointer = POINTER_OTHER;
  logic [15:0] req_x_ea = 16'h0000, req_y_ea = 16'h0000, req_wdata = 16'h0000;
  logic stall, result_valid, prog_read, prog_write, x_read, y_read;
  logic [15:0] reg_rdata, x_result, y_result, x_addr, y_addr, x_rdata, y_rdata;
  logic [2:0] prog_byte_enable;
  logic [23:0] fetch_address, prog_addr, prog_wdata, prog_rdata;
  int fail_count = 0;
  int n_compared = 0;
  logic [15:0] seed = 16'h0002; // lfsr state, fixed start
  always #10 clock = ~clock;
  program_space_address_mapper u_program_space_address_mapper (.clock, .resetn, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pc_load, .pc_load_value, .pc_advance,
    .fetch_address, .req, .req_kind, .req_class, .req_byte, .req_dual, .req_x_ea,
    .req_x_pointer, .req_y_ea, .req_y_pointer, .req_wdata, .repeat_active, .repeat_boundary,
    .stall, .result_valid, .x_result, .y_result, .prog_read, .prog_write, .prog_byte_enable,
    .prog_addr, .prog_wdata, .prog_rdata, .x_read, .x_addr, .x_rdata, .y_read, .y_addr,
    .y_rdata);
  program_memory_model u_program_memory_model (.clock, .prog_read, .prog_addr, .x_read,
    .x_addr, .y_read, .y_addr, .prog_rdata, .x_rdata, .y_rdata);
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [23:0] pword(input logic [23:0] p);
    return {p[7:0] ^ 8'h3c, p[15:0] ^ p[23:8]};
  endfunction
  // expected table read result from lane, mode and byte select
  function automatic logic [15:0] tbl(input logic hi, by, sel, input logic [23:0] w);
    if (!hi) return by ? {8'h00, sel ? w[15:8] : w[7:0]} : w[15:0];
    return (by && sel) ? 16'h0000 : {8'h00, w[23:16]};
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    check(reg_rdata, exp);
  endtask
  // one access; latency counted in cycles from the request cycle
  task automatic access(input access_kind_t k, input instr_class_t c, input logic by, dual,
      input logic [15:0] xe, ye, input pointer_t xp, yp, input logic [1:0] rep,
      output logic [15:0] xr, yr, output int lat);
    @(posedge clock);
    req <= 1'b1;
    req_kind <= k;
    req_class <= c;
    req_byte <= by;
    req_dual <= dual;
    req_x_ea <= xe;
    req_y_ea <= ye;
    req_x_pointer <= xp;
    req_y_pointer <= yp;
    req_wdata <= rnd();
    repeat_active <= rep[1];
    repeat_boundary <= rep[0];
    @(posedge clock);
    req <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge clock);
      lat++;
    end
    while (result_valid !== 1'b1 && lat < 12);
    xr = x_result;
    yr = y_result;
  endtask
  // watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge clock);
    fail_count++;
    complete_run();
  end
  initial
  begin
    logic [15:0] a, b, xr, yr;
    logic [23:0] w;
    int lat;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    a = rnd();
    b = rnd();
    reg_wr(2'h0, a);
    reg_wr(2'h1, b);
    reg_rd(2'h0, {8'h00, a[7:0]});
    reg_rd(2'h1, {8'h00, b[7:0]});
    // fetch: load, then one word step
    w = {rnd(), rnd()};
    @(posedge clock);
    pc_load <= 1'b1;
    pc_load_value <= w[22:0];
    @(posedge clock);
    pc_load <= 1'b0;
    pc_advance <= 1'b1;
    @(posedge clock);
    pc_advance <= 1'b0;
    @(negedge clock);
    check(fetch_address, {1'b0, w[22:1], 1'b0});
    @(negedge clock);
    check(fetch_address, ({1'b0, w[22:1], 1'b0} + 24'h2) & 24'h7ffffe);
    // table ops with mapping enabled: mapping must not add cycles
    reg_wr(2'h2, 16'h0004);
    for (int i = 0; i < 16; i++)
    begin
      a = rnd();
      b = rnd();
      reg_wr(2'h0, b);
      access(access_kind_t'(3'(i[1:0]) + 3'h1), CLASS_OTHER, i[2], 1'b0, a, 16'h0000,
        POINTER_OTHER, POINTER_OTHER, 2'h0, xr, yr, lat);
      w = pword({b[7:0], a});
      if (!i[1]) check(xr, tbl(i[0], i[2], a[0], w));
      check(lat[23:0], 24'h3);
    end
    // mapped reads for every class, in and out of a repeat loop
    for (int i = 0; i < 16; i++)
    begin
      a = rnd() | 16'h8000;
      b = rnd();
      reg_wr(2'h1, b);
      access(ACCESS_DATA, instr_class_t'(i[1:0]), 1'b0, 1'b0, a, 16'h0000, POINTER_OTHER,
        POINTER_OTHER, i[3:2], xr, yr, lat);
      w = pword({1'b0, b[7:0], a[14:0]});
      check(xr, w[15:0]);
      check(lat[23:0], 24'(3 + (i[3] ? (i[2] ? 2 : 0) : (i[1:0] == 2'h3 ? 2 : 1))));
    end
    // mapping off: upper half is unimplemented data
    reg_wr(2'h2, 16'h0000);
    access(ACCESS_DATA, CLASS_MOVE, 1'b0, 1'b0, rnd() | 16'h8000, 16'h0000, POINTER_OTHER,
      POINTER_OTHER, 2'h0, xr, yr, lat);
    check(xr, 16'h0000);
    // plain reads see the whole implemented space, y block included
    for (int i = 0; i < 8; i++)
    begin
      a = rnd() & 16'h0ffe;
      access(ACCESS_DATA, CLASS_MOVE, 1'b0, 1'b0, a, 16'h0000, POINTER_OTHER,
        POINTER_OTHER, 2'h0, xr, yr, lat);
      check(xr, a ^ 16'h6d2b);
      check(yr, 16'h0000);
    end
    // dual operand: each pointer only inside its own region
    a = rnd() & 16'h03fe;
    access(ACCESS_DATA, CLASS_DUAL_PREFETCH, 1'b0, 1'b1, 16'h0800 | a, 16'h0800 | a,
      X_POINTER_A, Y_POINTER_A, 2'h0, xr, yr, lat);
    check(xr, 16'h0000);
    check(yr, (16'h0800 | a) ^ 16'h1e97);
    access(ACCESS_DATA, CLASS_DUAL_PREFETCH, 1'b0, 1'b1, a, a, X_POINTER_B, Y_POINTER_B,
      2'h0, xr, yr, lat);
    check(xr, a ^ 16'h6d2b);
    check(yr, 16'h0000);
    complete_run();
  end
endmodule
bind program_space_address_mapper program_space_address_mapper_props
  u_program_space_address_mapper_props (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
  .pc_load, .pc_advance, .fetch_address, .req, .req_kind, .req_dual, .req_x_ea, .stall,
  .result_valid, .x_result, .prog_read, .prog_write, .prog_byte_enable, .prog_addr, .y_read);
